/* cfm_mode_ctrl.sv */
// Purpose: APB-reached mode-entry controller of a CAN protocol engine.
// Assumes: Bus-side events are posted by software through the bus event register.
// Notes:   Mode steps take a whole number of CAN bit times counted by child modules.
//
// How it works
// - With freeze enabled, setting halt drives the controller to freeze and sets freeze_ack.
// - A frame pending while freeze or low power is requested in bus-off is sent intact later.
// - Soft reset set by the host is cleared by the controller on completion within two bits.
// - After soft reset the controller sets freeze_ack within two bit times.
// - After halt the controller sets freeze_ack within 178 bit times.
// - After a low-power request while frozen the controller sets low_power_ack within two bit times.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
module cfm_mode_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             freeze_ack,
  output logic             low_power_ack,
  output logic             tx_active
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cfm_pkg::cfm_mode_t mode_r;
  cfm_pkg::cfm_apb_req_t req;
  logic        module_disable_r;
  logic        freeze_enable_r;
  logic        halt_r;
  logic        soft_reset_r;
  logic        low_power_req_r;
  logic [31:0] int_mask_r;
  logic [15:0] prescale_r;
  logic [1:0]  fcs_r;
  logic        tx_pending_r;
  logic        tx_intact_r;
  logic        bit_tick;
  logic        step_start;
  logic        step_done;
  logic [7:0]  step_bits;
  logic        wr_acc;
  logic        wr_ctrl;
  logic        wr_evt;
  logic        mapped;
  logic [31:0] ctrl_view;
  logic        quiet;

  assign req = '{sel: psel, en: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // Every access completes in its first access cycle.
  assign wr_acc = req.sel && req.en && req.write && pready;
  assign wr_ctrl = wr_acc && (req.addr == cfm_pkg::MODULE_CONTROL_REG_OFF);
  assign wr_evt = wr_acc && (req.addr == cfm_pkg::BUS_EVENT_OFF);

  assign mapped = (req.addr == cfm_pkg::MODULE_CONTROL_REG_OFF) ||
                  (req.addr == cfm_pkg::ERROR_STATUS_REG_OFF) ||
                  (req.addr == cfm_pkg::INTERRUPT_MASK_OFF) ||
                  (req.addr == cfm_pkg::BIT_TIMING_OFF) ||
                  (req.addr == cfm_pkg::BUS_EVENT_OFF) ||
                  (req.addr == cfm_pkg::IDENT_OFF);

  // Frozen, disabled and low-power states stop all bus activity.
  assign quiet = (mode_r != cfm_pkg::CFM_RUN);

  // ----------------------------------------------------------------------
  // Bit timing children
  // ----------------------------------------------------------------------
  cfm_bit_timer u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (step_start),
    .prescale (prescale_r),
    .bit_tick (bit_tick)
  );

  cfm_step_counter u_step (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (step_start),
    .bits     (step_bits),
    .bit_tick (bit_tick),
    .done     (step_done)
  );

  // ----------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------
  // Pick the next step and its length; a step starts on entry to its state.
  always_comb begin
    step_start = 1'b0;
    step_bits  = cfm_pkg::FREEZE_BITS;
    unique case (mode_r)
      cfm_pkg::CFM_RUN: begin
        if (soft_reset_r) begin
          step_start = 1'b1;
          step_bits  = cfm_pkg::SOFT_RESET_BITS;
        end else if (freeze_enable_r && halt_r) begin
          step_start = 1'b1;
          step_bits  = cfm_pkg::FREEZE_BITS;
        end
      end
      cfm_pkg::CFM_FROZEN: begin
        if (soft_reset_r) begin
          step_start = 1'b1;
          step_bits  = cfm_pkg::SOFT_RESET_BITS;
        end else if (low_power_req_r) begin
          step_start = 1'b1;
          step_bits  = cfm_pkg::LOW_POWER_BITS;
        end else if (!halt_r || !freeze_enable_r) begin
          step_start = 1'b1;
          step_bits  = cfm_pkg::UNFREEZE_BITS;
        end
      end
      cfm_pkg::CFM_DISABLED: begin
        if (!module_disable_r) begin
          step_start = 1'b1;
          step_bits  = cfm_pkg::LOW_POWER_BITS;
        end
      end
      cfm_pkg::CFM_LP: begin
        if (!low_power_req_r) begin
          step_start = 1'b1;
          step_bits  = cfm_pkg::LOW_POWER_BITS;
        end
      end
      default: begin
        step_start = 1'b0;
      end
    endcase
  end

  // Mode transitions; soft reset ends in freeze, since freeze_enable and halt reset set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= cfm_pkg::CFM_DISABLED;
    end else begin
      unique case (mode_r)
        cfm_pkg::CFM_RUN:
          if (step_start) mode_r <= soft_reset_r ? cfm_pkg::CFM_SRST
                                                 : cfm_pkg::CFM_FREEZING;
        cfm_pkg::CFM_FREEZING:
          if (step_done) mode_r <= cfm_pkg::CFM_FROZEN;
        cfm_pkg::CFM_SRST:
          if (step_done) mode_r <= cfm_pkg::CFM_FROZEN;
        cfm_pkg::CFM_FROZEN:
          if (step_start) begin
            if (soft_reset_r) mode_r <= cfm_pkg::CFM_SRST;
            else if (low_power_req_r) mode_r <= cfm_pkg::CFM_LP_ENTER;
            else mode_r <= cfm_pkg::CFM_THAW;
          end
        cfm_pkg::CFM_LP_ENTER:
          if (step_done) mode_r <= cfm_pkg::CFM_LP;
        cfm_pkg::CFM_LP:
          if (step_start) mode_r <= cfm_pkg::CFM_THAW;
        cfm_pkg::CFM_DISABLED:
          if (step_start) mode_r <= cfm_pkg::CFM_THAW;
        cfm_pkg::CFM_THAW:
          if (step_done) mode_r <= cfm_pkg::CFM_RUN;
      endcase
    end
  end

  // Acknowledge flags follow the mode and are registered outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze_ack    <= 1'b0;
      low_power_ack <= 1'b1;
    end else begin
      freeze_ack    <= (mode_r == cfm_pkg::CFM_FROZEN);
      low_power_ack <= (mode_r == cfm_pkg::CFM_LP) ||
                       (mode_r == cfm_pkg::CFM_DISABLED);
    end
  end

  // ----------------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------------
  // Software writes control bits; completing a soft reset restores defaults, except that disable is cleared and prescale is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_disable_r <= cfm_pkg::CTRL_RESET_VALUE[cfm_pkg::CTRL_MODULE_DISABLE_BIT];
      freeze_enable_r  <= cfm_pkg::CTRL_RESET_VALUE[cfm_pkg::CTRL_FREEZE_ENABLE_BIT];
      halt_r           <= cfm_pkg::CTRL_RESET_VALUE[cfm_pkg::CTRL_HALT_BIT];
      soft_reset_r     <= 1'b0;
      low_power_req_r  <= 1'b0;
      int_mask_r       <= cfm_pkg::MASK_RESET_VALUE;
      prescale_r       <= cfm_pkg::PRESCALE_RESET;
    end else if (mode_r == cfm_pkg::CFM_SRST && step_done) begin
      // Defaults except disable and prescale; a soft reset written in this same cycle still sticks.
      module_disable_r <= 1'b0;
      freeze_enable_r  <= cfm_pkg::CTRL_RESET_VALUE[cfm_pkg::CTRL_FREEZE_ENABLE_BIT];
      halt_r           <= cfm_pkg::CTRL_RESET_VALUE[cfm_pkg::CTRL_HALT_BIT];
      soft_reset_r     <= wr_ctrl && req.wdata[cfm_pkg::CTRL_SOFT_RESET_BIT];
      low_power_req_r  <= 1'b0;
      int_mask_r       <= cfm_pkg::MASK_RESET_VALUE;
    end else begin
      if (wr_ctrl) begin
        module_disable_r <= req.wdata[cfm_pkg::CTRL_MODULE_DISABLE_BIT];
        freeze_enable_r  <= req.wdata[cfm_pkg::CTRL_FREEZE_ENABLE_BIT];
        halt_r           <= req.wdata[cfm_pkg::CTRL_HALT_BIT];
        low_power_req_r  <= req.wdata[cfm_pkg::CTRL_LOW_POWER_REQ_BIT];
        // Soft reset is set-only from software; hardware alone clears it.
        soft_reset_r     <= soft_reset_r | req.wdata[cfm_pkg::CTRL_SOFT_RESET_BIT];
      end
      if (wr_acc && req.addr == cfm_pkg::INTERRUPT_MASK_OFF) begin
        int_mask_r <= req.wdata;
      end
      if (wr_acc && req.addr == cfm_pkg::BIT_TIMING_OFF) begin
        prescale_r <= req.wdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus-side state and pending frame
  // ----------------------------------------------------------------------
  // Confinement state; soft reset returns it to error active.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcs_r <= cfm_pkg::FCS_ERROR_ACTIVE;
    end else if (mode_r == cfm_pkg::CFM_SRST && step_done) begin
      fcs_r <= cfm_pkg::FCS_ERROR_ACTIVE;
    end else if (wr_evt && req.wdata[cfm_pkg::EVT_ENTER_BUS_OFF]) begin
      fcs_r <= cfm_pkg::FCS_BUS_OFF;
    end else if (wr_evt && req.wdata[cfm_pkg::EVT_LEAVE_BUS_OFF]) begin
      fcs_r <= cfm_pkg::FCS_ERROR_ACTIVE;
    end
  end

  // The frame is kept whole across freeze, low power and bus-off; it is
  // resent from its start, never from a cut point, and a queue event that
  // meets a completion in the same cycle keeps the frame pending.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pending_r <= 1'b0;
      tx_intact_r  <= 1'b1;
    end else begin
      if (wr_evt && req.wdata[cfm_pkg::EVT_QUEUE_TX]) begin
        tx_pending_r <= 1'b1;
        tx_intact_r  <= 1'b1;
      end else if (wr_evt && req.wdata[cfm_pkg::EVT_TX_DONE] && tx_active) begin
        tx_pending_r <= 1'b0;
      end
    end
  end

  // Transmission only while running and not bus-off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active <= 1'b0;
    end else begin
      tx_active <= tx_pending_r && !quiet && (fcs_r != cfm_pkg::FCS_BUS_OFF);
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[cfm_pkg::CTRL_MODULE_DISABLE_BIT] = module_disable_r;
    ctrl_view[cfm_pkg::CTRL_FREEZE_ENABLE_BIT]  = freeze_enable_r;
    ctrl_view[cfm_pkg::CTRL_HALT_BIT]           = halt_r;
    ctrl_view[cfm_pkg::CTRL_SOFT_RESET_BIT]     = soft_reset_r;
    ctrl_view[cfm_pkg::CTRL_FREEZE_ACK_BIT]     = freeze_ack;
    ctrl_view[cfm_pkg::CTRL_LOW_POWER_ACK_BIT]  = low_power_ack;
    ctrl_view[cfm_pkg::CTRL_LOW_POWER_REQ_BIT]  = low_power_req_r;
    ctrl_view[cfm_pkg::CTRL_TX_PENDING_BIT]     = tx_pending_r;
    ctrl_view[cfm_pkg::CTRL_TX_INTACT_BIT]      = tx_intact_r;
  end

  // Ready rises in the first access cycle, so every transfer has one wait-free access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (req.sel && !req.en) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      unique case (req.addr)
        cfm_pkg::MODULE_CONTROL_REG_OFF: prdata <= ctrl_view;
        cfm_pkg::ERROR_STATUS_REG_OFF:
          prdata <= {26'h0000000, fcs_r, 4'h0};
        cfm_pkg::INTERRUPT_MASK_OFF: prdata <= int_mask_r;
        cfm_pkg::BIT_TIMING_OFF: prdata <= {16'h0000, prescale_r};
        cfm_pkg::IDENT_OFF: prdata <= cfm_pkg::IDENT_VALUE;
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

endmodule

/* cfm_pkg.sv */
// Purpose: Shared constants and types for the CAN mode-entry controller.
// Assumes: 200 MHz APB clock; CAN bit time set by a software-written prescaler.
// Notes:   All offsets are byte addresses of aligned 32-bit words.
package cfm_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] MODULE_CONTROL_REG_OFF = 12'h000;
  localparam logic [11:0] ERROR_STATUS_REG_OFF   = 12'h004;
  localparam logic [11:0] INTERRUPT_MASK_OFF     = 12'h008;
  localparam logic [11:0] BIT_TIMING_OFF         = 12'h00c;
  localparam logic [11:0] BUS_EVENT_OFF          = 12'h010;
  localparam logic [11:0] IDENT_OFF              = 12'h014;

  // ----------------------------------------------------------------------
  // Module control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_MODULE_DISABLE_BIT = 31;
  localparam int CTRL_FREEZE_ENABLE_BIT  = 30;
  localparam int CTRL_HALT_BIT           = 28;
  localparam int CTRL_SOFT_RESET_BIT     = 25;
  localparam int CTRL_FREEZE_ACK_BIT     = 24;
  localparam int CTRL_LOW_POWER_ACK_BIT  = 20;
  localparam int CTRL_LOW_POWER_REQ_BIT  = 19;
  localparam int CTRL_TX_PENDING_BIT     = 18;
  localparam int CTRL_TX_INTACT_BIT      = 17;

  // Module control reset value: module disabled, freeze enabled, halted.
  localparam logic [31:0] CTRL_RESET_VALUE = 32'hd000_0000;
  localparam logic [31:0] MASK_RESET_VALUE = 32'h0000_0000;
  localparam logic [15:0] PRESCALE_RESET   = 16'h0013;

  // Error status: fault confinement field at bits 5:4.
  localparam int ESR_FCS_LSB = 4;
  localparam logic [1:0] FCS_ERROR_ACTIVE  = 2'h0;
  localparam logic [1:0] FCS_ERROR_PASSIVE = 2'h1;
  localparam logic [1:0] FCS_BUS_OFF       = 2'h2;

  // Bus event command register bits (write-only strobes).
  localparam int EVT_ENTER_BUS_OFF = 0;
  localparam int EVT_LEAVE_BUS_OFF = 1;
  localparam int EVT_QUEUE_TX      = 2;
  localparam int EVT_TX_DONE       = 3;

  // Identification value is arbitrary.
  localparam logic [31:0] IDENT_VALUE = 32'h0c0f_0001;

  // ----------------------------------------------------------------------
  // Timing: bit counts that the sequencer takes for each mode step
  // ----------------------------------------------------------------------
  localparam logic [7:0] SOFT_RESET_BITS = 8'h01;
  localparam logic [7:0] FREEZE_BITS     = 8'h03;
  localparam logic [7:0] LOW_POWER_BITS  = 8'h01;
  localparam logic [7:0] UNFREEZE_BITS   = 8'h01;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CFM_RUN      = 3'h0,
    CFM_FREEZING = 3'h1,
    CFM_FROZEN   = 3'h2,
    CFM_SRST     = 3'h3,
    CFM_LP_ENTER = 3'h4,
    CFM_LP       = 3'h5,
    CFM_DISABLED = 3'h6,
    CFM_THAW     = 3'h7
  } cfm_mode_t;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cfm_apb_req_t;

  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
    logic        slverr;
  } cfm_apb_rsp_t;

endpackage

/* cfm_bit_timer.sv */
// Purpose: CAN bit-time tick generator from the APB clock.
// Assumes: Prescale value is stable while counting; a value of n gives n+1 clocks per bit.
// Notes:   Restart lines the tick phase up with a mode step's start.
module cfm_bit_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        restart,
  input  wire logic [15:0] prescale,
  output logic             bit_tick
);

  logic [15:0] count_r;

  // Count down one bit period and tick at its end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r  <= 16'h0000;
      bit_tick <= 1'b0;
    end else if (restart) begin
      count_r  <= prescale;
      bit_tick <= 1'b0;
    end else if (count_r == 16'h0000) begin
      count_r  <= prescale;
      bit_tick <= 1'b1;
    end else begin
      count_r  <= count_r - 16'h0001;
      bit_tick <= 1'b0;
    end
  end

endmodule

/* cfm_step_counter.sv */
// Purpose: Counts CAN bit ticks for one mode step and flags its end.
// Assumes: Start is a one-cycle pulse; ticks come from the bit timer.
// Notes:   Done is a one-cycle pulse; a new start aborts a running count.
module cfm_step_counter (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [7:0] bits,
  input  wire logic       bit_tick,
  output logic            done
);

  logic [7:0] left_r;
  logic       busy_r;

  // Load on start, count ticks down, pulse done on the last one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 8'h00;
      busy_r <= 1'b0;
      done   <= 1'b0;
    end else if (start) begin
      left_r <= bits;
      busy_r <= 1'b1;
      done   <= 1'b0;
    end else if (busy_r && bit_tick) begin
      left_r <= left_r - 8'h01;
      busy_r <= (left_r != 8'h01);
      done   <= (left_r == 8'h01);
    end else begin
      done   <= 1'b0;
    end
  end

endmodule

/* cfm_mode_ctrl_monitor.sv */
// Purpose: Port-level checks of the CAN mode-entry controller.
// Assumes: A CAN bit is at most twenty clocks long, as after reset.
// Notes:   Bounds cover a mode step, a timer restart and the flag delay.
module cfm_mode_ctrl_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        freeze_ack,
  input wire logic        low_power_ack,
  input wire logic        tx_active
);
  localparam int FREEZE_MAX = 200;
  localparam int STEP_MAX   = 80;
  logic          ctrl_wr;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // A write to the control register that has just been taken.
  assign ctrl_wr = psel && penable && pready && pwrite && (paddr == 12'h000);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Zero wait states keep every transfer to two cycles.
  property p_rdy; psel && !penable ##1 psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing in access cycle");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_idle; !pready |-> (prdata == 32'h0) && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("read bus not quiet");
  property p_unmapped; pready && psel && (paddr > 12'h014) |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error for unmapped address");
  // Freeze request with freeze enabled must reach freeze_ack in time.
  property p_halt;
    ctrl_wr && pwdata[30] && pwdata[28] && !pwdata[31] && !pwdata[25] && !pwdata[19]
      && !low_power_ack |-> ##[1:FREEZE_MAX] freeze_ack;
  endproperty
  a_halt: assert property (p_halt) else $error("freeze_ack late after halt");
  property p_srst; ctrl_wr && pwdata[25] && !low_power_ack |-> ##[1:STEP_MAX] freeze_ack;
  endproperty
  a_srst: assert property (p_srst) else $error("no freeze after soft reset");
  property p_lp;
    ctrl_wr && pwdata[19] && pwdata[30] && pwdata[28] && !pwdata[31] && !pwdata[25]
      && freeze_ack |-> ##[1:STEP_MAX] low_power_ack;
  endproperty
  a_lp: assert property (p_lp) else $error("low_power_ack late");
  // A frame must never go out while frozen, where it would be cut.
  property p_freeze_tx; freeze_ack |-> !tx_active; endproperty
  a_freeze_tx: assert property (p_freeze_tx) else $error("transmit while frozen");
  property p_lp_tx; low_power_ack |-> !tx_active; endproperty
  a_lp_tx: assert property (p_lp_tx) else $error("transmit in low power");
endmodule

bind cfm_mode_ctrl cfm_mode_ctrl_monitor mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .freeze_ack(freeze_ack), .low_power_ack(low_power_ack), .tx_active(tx_active)
);

/* cfm_host_model.sv */
// Purpose: Host model that runs the mode-entry sequences over APB.
// Assumes: The bench has set a bit time of BIT_CLKS clocks.
// Notes:   A poll past its bound clears ok and the sequence stops.
module cfm_host_model #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic             pclk,
  input  wire logic             pready,
  input  wire logic [31:0]      prdata,
  input  wire logic             pslverr,
  output cfm_pkg::cfm_apb_req_t req
);
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  int                     cyc = 0;
  logic [31:0]            rd;
  logic                   er;

  // ------------------------------------------------------------------
  // Bus and sequences
  // ------------------------------------------------------------------
  initial req = '0;
  // Free cycle count that poll deadlines are taken from.
  always @(posedge pclk) cyc <= cyc + 1;

  // One transfer; the request stands until pready is seen at an edge.
  // No cycle count is assumed: only the bench timeout ends a missing answer.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{sel: 1'b1, en: 1'b0, write: w, addr: a, wdata: d};
    @(posedge pclk);
    req.en <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req <= '0;
    @(posedge pclk);
  endtask

  // Poll one control bit for a value within a number of bit times.
  task automatic poll(input int b, input logic v, input int bits, inout logic ok);
    int dl;
    dl = cyc + (bits + 1) * BIT_CLKS + 8;
    if (ok) begin
      do xfer(1'b0, CTRL_ADDR, 32'h0); while (rd[b] !== v && cyc < dl);
      if (rd[b] !== v) ok = 1'b0;
    end
  endtask

  // Freeze entry; the soft-reset path is taken when bus-off.
  task automatic enter_freeze(output logic ok, output logic boff, input logic [31:0] mask);
    logic [31:0] w;
    ok = 1'b1;
    xfer(1'b0, CTRL_ADDR, 32'h0);
    w = (rd & 32'hd000_0000) | 32'h4000_0000;
    xfer(1'b1, CTRL_ADDR, w);
    if (w[31]) begin
      w[31] = 1'b0;
      xfer(1'b1, CTRL_ADDR, w);
    end
    poll(20, 1'b0, 2, ok);
    xfer(1'b0, 12'h004, 32'h0);
    boff = (rd[5:4] === cfm_pkg::FCS_BUS_OFF);
    if (ok && boff) begin
      xfer(1'b1, CTRL_ADDR, w | 32'h0200_0000);
      poll(25, 1'b0, 2, ok);
      poll(24, 1'b1, 2, ok);
      if (ok) begin
        xfer(1'b1, CTRL_ADDR, w | 32'h1000_0000);
        xfer(1'b1, 12'h008, mask);
      end
    end else if (ok) begin
      xfer(1'b1, CTRL_ADDR, w | 32'h1000_0000);
      poll(24, 1'b1, 178, ok);
    end
  endtask

  // Low power is only asked for once freeze entry is complete.
  task automatic enter_lp(output logic ok);
    logic boff;
    enter_freeze(ok, boff, 32'h0);
    if (ok) xfer(1'b1, CTRL_ADDR, 32'h5008_0000);
    poll(20, 1'b1, 2, ok);
  endtask
endmodule

/* cfm_mode_ctrl_tb.sv */
// Purpose: Self-checking bench for the CAN mode-entry controller.
// Assumes: Prescaler set to 3, so one bit is four clocks.
// Notes:   Bus-side events are posted through the bus event register.
module cfm_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  cfm_pkg::cfm_apb_req_t req;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  pready, pslverr, freeze_ack, low_power_ack, tx_active;
  logic [31:0]           prdata;
  logic                  ok, boff;
  int                    err_count = 0;
  int                    checked = 0;
  int                    cycles = 0;

  cfm_mode_ctrl dut_u (
    .pclk(pclk), .presetn(presetn), .psel(req.sel), .penable(req.en), .pwrite(req.write),
    .paddr(req.addr), .pwdata(req.wdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .freeze_ack(freeze_ack), .low_power_ack(low_power_ack),
    .tx_active(tx_active));
  cfm_host_model #(.BIT_CLKS(4)) host_u (
    .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .req(req));

  // ------------------------------------------------------------------
  // Clock, timeout and reporting
  // ------------------------------------------------------------------
  initial forever #2.5 pclk = ~pclk;
  // The whole run needs a few hundred cycles; a hang is cut well after.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Reset state, identity, unmapped access and the prescaler.
  task automatic t_reset();
    chk("freeze_ack", 1'b0, freeze_ack);
    chk("low_power_ack", 1'b1, low_power_ack);
    host_u.xfer(1'b0, 12'h000, 32'h0);
    chk("control", cfm_pkg::CTRL_RESET_VALUE, host_u.rd & 32'hd000_0000);
    host_u.xfer(1'b0, cfm_pkg::IDENT_OFF, 32'h0);
    chk("ident", cfm_pkg::IDENT_VALUE, host_u.rd);
    host_u.xfer(1'b1, 12'h020, 32'hffff_ffff);
    chk("unmapped err", 1'b1, host_u.er);
    host_u.xfer(1'b0, 12'h020, 32'h0);
    chk("unmapped data", 32'h0, host_u.rd);
    host_u.xfer(1'b1, cfm_pkg::BIT_TIMING_OFF, 32'h3);
    host_u.xfer(1'b0, cfm_pkg::BIT_TIMING_OFF, 32'h0);
    chk("prescale", 32'h3, host_u.rd & 32'hffff);
  endtask

  // Halt path out of the disabled state, then back to run.
  task automatic t_freeze();
    host_u.enter_freeze(ok, boff, 32'h0);
    chk("freeze seq", 1'b1, ok);
    chk("bus-off seen", 1'b0, boff);
    chk("freeze_ack", 1'b1, freeze_ack);
    host_u.xfer(1'b1, 12'h000, 32'h4000_0000);
    for (int i = 0; i < 40 && freeze_ack !== 1'b0; i++) @(posedge pclk);
    chk("thawed", 1'b0, freeze_ack);
  endtask

  // Low-power entry, then release straight to run.
  task automatic t_lp();
    host_u.enter_lp(ok);
    chk("low power seq", 1'b1, ok);
    chk("low_power_ack", 1'b1, low_power_ack);
    host_u.xfer(1'b1, 12'h000, 32'h0);
    for (int i = 0; i < 40 && low_power_ack !== 1'b0; i++) @(posedge pclk);
    chk("low power left", 1'b0, low_power_ack);
  endtask

  // A frame queued in bus-off must survive the soft-reset freeze whole.
  task automatic t_busoff();
    host_u.xfer(1'b1, cfm_pkg::BUS_EVENT_OFF, 32'h1);
    host_u.xfer(1'b1, cfm_pkg::BUS_EVENT_OFF, 32'h4);
    chk("tx held", 1'b0, tx_active);
    host_u.enter_freeze(ok, boff, 32'h0000_00a5);
    chk("soft reset seq", 1'b1, ok);
    chk("bus-off seen", 1'b1, boff);
    host_u.xfer(1'b0, cfm_pkg::INTERRUPT_MASK_OFF, 32'h0);
    chk("mask", 32'ha5, host_u.rd);
    host_u.xfer(1'b0, cfm_pkg::ERROR_STATUS_REG_OFF, 32'h0);
    chk("fcs", cfm_pkg::FCS_ERROR_ACTIVE, host_u.rd[5:4]);
    host_u.xfer(1'b1, 12'h000, 32'h0);
    for (int i = 0; i < 40 && tx_active !== 1'b1; i++) @(posedge pclk);
    chk("tx resumed", 1'b1, tx_active);
    host_u.xfer(1'b1, cfm_pkg::BUS_EVENT_OFF, 32'h8);
    host_u.xfer(1'b0, 12'h000, 32'h0);
    chk("tx intact", 2'b01, host_u.rd[18:17]);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_freeze();
    t_lp();
    t_busoff();
    give_verdict();
  end
endmodule
